/* File: rtl/clk_sel_defs.svh */
`ifndef CLK_SEL_DEFS_SVH
`define CLK_SEL_DEFS_SVH

// Configuration word 2 field positions
`define CFG_PRIMARY_MODE_LSB   0
`define CFG_PRIMARY_MODE_MSB   1
`define CFG_SWITCH_MON_LSB     6
`define CFG_SWITCH_MON_MSB     7
`define CFG_INITIAL_SRC_LSB    8
`define CFG_INITIAL_SRC_MSB    10

// Unprogrammed (erased) configuration values
`define CFG_PRIMARY_MODE_RESET 2'h3
`define CFG_INITIAL_SRC_RESET  3'h7
`define CFG_SWITCH_MON_RESET   2'h3

// Multiplier factor and default postscaler divisor code
`define PLL_FACTOR             3'h4
`define POSTSCALE_RESET        3'h1

`endif

/* File: rtl/clk_sel_pkg.sv */
package clk_sel_pkg;

  // Source codes as carried by the initial-source field
  typedef enum logic [2:0] {
    SRC_FAST_RC      = 3'h0,
    SRC_FAST_RC_MULT = 3'h1,
    SRC_PRIMARY      = 3'h2,
    SRC_PRIMARY_MULT = 3'h3,
    SRC_SECONDARY    = 3'h4,
    SRC_LOW_POWER_RC = 3'h5,
    SRC_RESERVED     = 3'h6,
    SRC_FAST_RC_DIV  = 3'h7
  } source_t;

  // Primary oscillator submodes
  typedef enum logic [1:0] {
    PM_EXT_CLOCK = 2'h0,
    PM_CRYSTAL   = 2'h1,
    PM_FAST_CRYSTAL = 2'h2,
    PM_DISABLED  = 2'h3
  } primary_mode_t;

  // Oscillator root feeding the processor clock
  typedef enum logic [1:0] {
    ROOT_PRIMARY   = 2'h0,
    ROOT_SECONDARY = 2'h1,
    ROOT_FAST_RC   = 2'h3,
    ROOT_LOW_POWER = 2'h2
  } root_t;

endpackage

/* File: rtl/clock_source_select_config.sv */
// What this block does
// - The processor clock comes from exactly one of primary, secondary, fast RC or low-power RC.
// - The times-four multiplier may follow only the primary or the fast RC source.
// - In postscaled fast RC mode the fast RC enable passes a programmable divider first.
// - The instruction clock is the processor clock divided by two, and the processor clock feeds the peripherals.
// - Primary external-clock mode drives the instruction clock on the output pin, other primary modes release it, non-primary sources follow a config bit.
// - At power-on the mode comes from bits 1:0 of word 2; the source comes from bits 10:8 with switching disabled, else it stays 111.
// - Erased configuration selects fast RC with postscaler (source 111, mode 11).
// - Runtime switching is enabled only when bit 7 of word 2 is zero.
// - The fail-safe monitor is enabled only when bits 7:6 of word 2 are both zero.
// - With mode 11, codes 111,101,100,001,000 select their internal or secondary sources and 110 is reserved.
// - Code 011 is primary with multiplier and 010 plain primary, submode from the primary-mode field.
// - With switching disabled the new-source field is ignored and status shows the configured source.
// - With switching disabled the switch-request bit reads zero and writes do nothing.
`include "clk_sel_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module clock_source_select_config #(
  parameter int DIV_W = 3
) (
  // Clock, reset and clock enable
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  // Nonvolatile configuration word 2 and pin-function bit
  input  wire logic [15:0]                 cfg_word2,
  input  wire logic                        osc_out_pin_function_cfg,
  // Oscillator levels, rising edges counted as ticks (asynchronous sources)
  input  wire logic                        primary_osc,
  input  wire logic                        secondary_osc,
  input  wire logic                        fast_rc_osc,
  input  wire logic                        low_power_rc_osc,
  // Software control bits
  input  wire logic [2:0]                  new_source_select,
  input  wire logic                        switch_request_wr,
  input  wire logic                        switch_request_val,
  input  wire logic [DIV_W-1:0]            postscale_sel,
  // Clock outputs as enable pulses; the pin as a level with its active-low output enable
  output logic                             processor_clock,
  output logic                             instruction_cycle_clock,
  output logic                             osc_output_pin,
  output logic                             osc_output_pin_oe_n,
  // Status
  output clk_sel_pkg::source_t             current_source_status,
  output clk_sel_pkg::primary_mode_t       primary_mode_cfg,
  output logic                             switch_request_bit,
  output logic                             switch_enable,
  output logic                             failsafe_clock_monitor,
  output logic                             multiplier_on,
  output logic                             source_reserved
);
  import clk_sel_pkg::*;

  // Configuration held from power-on reset
  logic [2:0]       initial_source_cfg_r;
  logic [1:0]       primary_mode_r;
  logic [1:0]       switch_monitor_cfg_r;
  logic             cfg_loaded_r;
  // Synchronisers for the four oscillator ticks
  logic [3:0]       osc_meta_r;
  logic [3:0]       osc_sync_r;
  logic [3:0]       osc_prev_r;
  // Current source, switch request and dividers
  source_t          cur_src_r;
  source_t          cur_src_nxt;
  logic             switch_req_r;
  logic             switch_req_nxt;
  // Counter wide enough for the largest divide of 2**(2**DIV_W-1)
  localparam int    POST_W = 1 << DIV_W;
  logic [POST_W-1:0] post_cnt_r;
  logic [1:0]       pll_cnt_r;
  logic             half_phase_r;
  logic             proc_clk_r;
  logic             icyc_r;
  logic             pin_r;

  // Config sampled on the first ce edge after reset release; asynchronous reset loads erased values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initial_source_cfg_r <= `CFG_INITIAL_SRC_RESET;
      primary_mode_r       <= `CFG_PRIMARY_MODE_RESET;
      switch_monitor_cfg_r <= `CFG_SWITCH_MON_RESET;
      cfg_loaded_r         <= 1'b0;
    end else if (ce && !cfg_loaded_r) begin
      // One capture just after release, then frozen until next reset
      initial_source_cfg_r <=
        cfg_word2[`CFG_INITIAL_SRC_MSB:`CFG_INITIAL_SRC_LSB];
      primary_mode_r <=
        cfg_word2[`CFG_PRIMARY_MODE_MSB:`CFG_PRIMARY_MODE_LSB];
      switch_monitor_cfg_r <=
        cfg_word2[`CFG_SWITCH_MON_MSB:`CFG_SWITCH_MON_LSB];
      cfg_loaded_r <= 1'b1;
    end
  end

  // Decoded configuration
  wire cfg_switch_en  = !switch_monitor_cfg_r[1];
  wire cfg_monitor_en = (switch_monitor_cfg_r == 2'h0);
  wire [2:0] cfg_src  = initial_source_cfg_r;

  // Oscillator ticks come from other domains: two flops first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_meta_r <= 4'h0;
      osc_sync_r <= 4'h0;
      osc_prev_r <= 4'h0;
    end else if (ce) begin
      osc_meta_r <= {low_power_rc_osc, fast_rc_osc,
                     secondary_osc, primary_osc};
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  // Rising edges of each synchronised source
  wire [3:0] osc_edge = osc_sync_r & ~osc_prev_r;

  // Source selection; a switch request is honoured only when enabled
  always_comb begin
    cur_src_nxt    = cur_src_r;
    switch_req_nxt = switch_req_r;
    if (!cfg_loaded_r) begin
      cur_src_nxt    = source_t'(cfg_src);
      switch_req_nxt = 1'b0;
    end else if (!cfg_switch_en) begin
      cur_src_nxt    = source_t'(cfg_src);
      switch_req_nxt = 1'b0;
    end else if (switch_req_r) begin
      // Reserved code is refused, current source stays
      if (new_source_select != SRC_RESERVED) begin
        cur_src_nxt = source_t'(new_source_select);
      end
      switch_req_nxt = 1'b0;
    end else if (switch_request_wr) begin
      switch_req_nxt = switch_request_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_src_r    <= SRC_FAST_RC_DIV;
      switch_req_r <= 1'b0;
    end else if (ce) begin
      cur_src_r    <= cur_src_nxt;
      switch_req_r <= switch_req_nxt;
    end
  end

  // Root oscillator for the current source
  wire root_t root_sel =
    (cur_src_r == SRC_PRIMARY || cur_src_r == SRC_PRIMARY_MULT) ?
      ROOT_PRIMARY :
    (cur_src_r == SRC_SECONDARY)    ? ROOT_SECONDARY :
    (cur_src_r == SRC_LOW_POWER_RC) ? ROOT_LOW_POWER : ROOT_FAST_RC;
  wire root_tick = (root_sel == ROOT_PRIMARY)   ? osc_edge[0] :
                   (root_sel == ROOT_SECONDARY) ? osc_edge[1] :
                   (root_sel == ROOT_FAST_RC)   ? osc_edge[2] :
                                                  osc_edge[3];
  // Multiplier only behind primary or fast RC
  wire use_pll = (cur_src_r == SRC_PRIMARY_MULT) ||
                 (cur_src_r == SRC_FAST_RC_MULT);
  wire use_post = (cur_src_r == SRC_FAST_RC_DIV);

  // Postscaler: divide fast RC ticks by 2**postscale_sel
  wire [POST_W-1:0] post_lim = POST_W'((1 << postscale_sel) - 1);
  wire post_tick = (post_cnt_r >= post_lim);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      post_cnt_r <= '0;
    end else if (ce && use_post && root_tick) begin
      post_cnt_r <= post_tick ? '0 : post_cnt_r + 1'b1;
    end
  end

  // Multiplier: the tick arrives as a cycle-rate burst of four; a real
  // multiplier is analog, this models its tick count per source tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pll_cnt_r <= 2'h0;
    end else if (ce) begin
      if (use_pll && root_tick) begin
        pll_cnt_r <= 2'(`PLL_FACTOR - 3'h1);
      end else if (pll_cnt_r != 2'h0) begin
        pll_cnt_r <= pll_cnt_r - 2'h1;
      end
    end
  end

  // Processor clock tick after optional multiplier or postscaler
  wire proc_tick = use_pll  ? (root_tick || pll_cnt_r != 2'h0) :
                   use_post ? (root_tick && post_tick) : root_tick;
  // Output pin carries the instruction clock only for external clock
  // primary modes; internal and secondary follow the config bit
  wire is_primary = (root_sel == ROOT_PRIMARY);
  wire pin_drive  = is_primary ? (primary_mode_r == PM_EXT_CLOCK) :
                                 osc_out_pin_function_cfg;

  // Processor clock, instruction clock halving and pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_phase_r <= 1'b0;
      proc_clk_r   <= 1'b0;
      icyc_r       <= 1'b0;
      pin_r        <= 1'b0;
    end else if (ce) begin
      proc_clk_r <= proc_tick;
      if (proc_tick) begin
        half_phase_r <= ~half_phase_r;
      end
      icyc_r <= proc_tick && half_phase_r;
      pin_r  <= half_phase_r;
    end
  end

  // Outputs
  assign processor_clock         = proc_clk_r;
  assign instruction_cycle_clock = icyc_r;
  assign osc_output_pin          = pin_r & pin_drive;
  assign osc_output_pin_oe_n     = ~pin_drive;
  assign current_source_status   = cur_src_r;
  assign primary_mode_cfg        = primary_mode_t'(primary_mode_r);
  assign switch_request_bit      = switch_req_r;
  assign switch_enable           = cfg_switch_en;
  assign failsafe_clock_monitor  = cfg_monitor_en;
  assign multiplier_on           = use_pll;
  assign source_reserved         = (cur_src_r == SRC_RESERVED);

endmodule
`default_nettype wire

/* File: test/clk_sel_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module clk_sel_asserts (
  // Clock, reset and request inputs
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       ce,
  input wire logic                       switch_request_wr,
  input wire logic                       switch_request_val,
  input wire logic [2:0]                 new_source_select,
  // Watched outputs
  input wire logic                       instruction_cycle_clock,
  input wire logic                       osc_output_pin_oe_n,
  input wire clk_sel_pkg::source_t       current_source_status,
  input wire clk_sel_pkg::primary_mode_t primary_mode_cfg,
  input wire logic                       switch_request_bit,
  input wire logic                       switch_enable,
  input wire logic                       failsafe_clock_monitor,
  input wire logic                       multiplier_on,
  input wire logic                       source_reserved
);
  import clk_sel_pkg::*;
  logic [1:0] up_r;

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  // Status settles on the second ce edge; wait for three to be safe
  always_ff @(posedge clk or posedge rst)
    if (rst) up_r <= 2'h0;
    else if (ce && up_r != 2'h3) up_r <= up_r + 2'h1;

  // Request taken, then its one-cycle flag
  sequence req_taken;
    ce && switch_enable && switch_request_wr && switch_request_val &&
      new_source_select != 3'h6 ##1 switch_request_bit;
  endsequence

  a_switch_lands: assert property (req_taken |=>
    current_source_status == $past(new_source_select, 2) &&
    !switch_request_bit) else $error("switch missed its source");
  a_request_blocked: assert property (!switch_enable |->
    !switch_request_bit) else $error("request flag while locked");
  a_status_frozen: assert property (up_r == 2'h3 && !switch_enable |->
    $stable(current_source_status)) else $error("source moved while locked");
  a_config_held: assert property (up_r == 2'h3 |->
    $stable(primary_mode_cfg) && $stable(switch_enable) &&
    $stable(failsafe_clock_monitor)) else $error("config changed after load");
  a_monitor_needs_switch: assert property (failsafe_clock_monitor |->
    switch_enable) else $error("monitor on with switching off");
  a_mult_sources: assert property (multiplier_on ==
    (current_source_status inside {SRC_FAST_RC_MULT, SRC_PRIMARY_MULT}))
    else $error("multiplier on wrong source");
  a_reserved_flag: assert property (source_reserved ==
    (current_source_status == SRC_RESERVED)) else $error("reserved flag wrong");
  a_tick_spacing: assert property (instruction_cycle_clock |=>
    !instruction_cycle_clock) else $error("instruction ticks adjacent");
  a_pin_released: assert property (primary_mode_cfg != PM_EXT_CLOCK &&
    current_source_status inside {SRC_PRIMARY, SRC_PRIMARY_MULT} |->
    osc_output_pin_oe_n) else $error("pin driven in crystal submode");
endmodule

bind clock_source_select_config clk_sel_asserts u_chk (.clk, .rst, .ce,
  .switch_request_wr, .switch_request_val, .new_source_select,
  .instruction_cycle_clock, .osc_output_pin_oe_n, .current_source_status,
  .primary_mode_cfg, .switch_request_bit, .switch_enable,
  .failsafe_clock_monitor, .multiplier_on, .source_reserved);
`default_nettype wire

/* File: test/osc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module osc_model #(parameter int PRIM_HALF = 53, SECD_HALF = 251,
                   FAST_HALF = 47, LOWP_HALF = 149) (
  // Oscillator levels at the device inputs
  output logic primary_osc,
  output logic secondary_osc,
  output logic fast_rc_osc,
  output logic low_power_rc_osc
);
  // Free-running, odd half periods walk edges across the clk grid; every tenth lands on a rising clk edge
  initial {primary_osc, secondary_osc, fast_rc_osc, low_power_rc_osc} = 4'h0;
  always #(PRIM_HALF) primary_osc = ~primary_osc;
  always #(SECD_HALF) secondary_osc = ~secondary_osc;
  always #(FAST_HALF) fast_rc_osc = ~fast_rc_osc;
  always #(LOWP_HALF) low_power_rc_osc = ~low_power_rc_osc;
endmodule
`default_nettype wire

/* File: test/tb_clock_source_select_config.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_clock_source_select_config;
  import clk_sel_pkg::*;
  localparam int W = 360, PH = 53, SH = 251, FH = 47, LH = 149;
  logic          clk, rst, ce, osc_out_pin_function_cfg, switch_request_wr;
  logic          switch_request_val, processor_clock, instruction_cycle_clock;
  logic          osc_output_pin, osc_output_pin_oe_n, switch_request_bit;
  logic          switch_enable, failsafe_clock_monitor, multiplier_on;
  logic          source_reserved;
  logic [15:0]   cfg_word2;
  logic [2:0]    new_source_select, postscale_sel;
  source_t       current_source_status;
  primary_mode_t primary_mode_cfg;
  wire           primary_osc, secondary_osc, fast_rc_osc, low_power_rc_osc;
  int            num_errors = 0, tests_run = 0;

  // Far-side oscillators and the block under test
  osc_model #(.PRIM_HALF(PH), .SECD_HALF(SH), .FAST_HALF(FH), .LOWP_HALF(LH))
    u_osc (.primary_osc, .secondary_osc, .fast_rc_osc, .low_power_rc_osc);
  clock_source_select_config #(.DIV_W(3)) u_dut (.clk, .rst, .ce, .cfg_word2,
    .osc_out_pin_function_cfg, .primary_osc, .secondary_osc, .fast_rc_osc,
    .low_power_rc_osc, .new_source_select, .switch_request_wr,
    .switch_request_val, .postscale_sel, .processor_clock,
    .instruction_cycle_clock, .osc_output_pin, .osc_output_pin_oe_n,
    .current_source_status, .primary_mode_cfg, .switch_request_bit,
    .switch_enable, .failsafe_clock_monitor, .multiplier_on, .source_reserved);

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Reset is the only way config is reloaded
  task automatic boot(logic [2:0] fn, logic [1:0] sm, logic [1:0] pmc);
    @(posedge clk);
    rst <= 1'b1;
    cfg_word2 <= {5'h1F, fn, sm, 4'hF, pmc};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Boot one configuration, judge status and tick rates
  task automatic src_case(logic [2:0] fn, logic [1:0] pmc, int half, m, d);
    int n, ic, e, p;
    boot(fn, 2'h3, pmc);
    chk("source", fn, current_source_status);
    chk("mode", pmc, primary_mode_cfg);
    chk("sw mon", 0, {switch_enable, failsafe_clock_monitor});
    chk("mult", fn inside {3'h1, 3'h3}, multiplier_on);
    chk("resv", fn == 3'h6, source_reserved);
    if (fn == 3'h2) chk("pin oe", pmc != 2'h0, osc_output_pin_oe_n);
    if (half > 0) begin
      n = 0;
      ic = 0;
      p = 0;
      repeat (W) begin
        @(posedge clk);
        #1;
        n += processor_clock;
        ic += instruction_cycle_clock;
        p += osc_output_pin;
      end
      chk("pin toggles", fn inside {3'h2, 3'h3} && pmc == 2'h0, p > 0);
      // Window edges may clip one source edge at each end
      e = W * 10 / (2 * half);
      tests_run++;
      if (n < (e - 2) * m / d || n > (e + 2) * m / d ||
          ic * 2 < n - 1 || ic * 2 > n + 1) begin
        num_errors++;
        $display("wrong value ticks expected %0d seen %0d", e * m / d, n);
      end
    end
  endtask

  // One switch request and its two-cycle answer
  task automatic req(logic [2:0] s, logic [2:0] e, logic b);
    @(posedge clk);
    new_source_select <= s;
    switch_request_wr <= 1'b1;
    @(posedge clk);
    switch_request_wr <= 1'b0;
    #1;
    chk("req bit", b, switch_request_bit);
    @(posedge clk);
    #1;
    chk("switched", e, current_source_status);
    chk("req clear", 0, switch_request_bit);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #500_000;
    num_errors++;
    close_out;
  end

  initial begin
    {rst, ce, osc_out_pin_function_cfg} = 3'h6;
    {switch_request_wr, switch_request_val} = 2'h1;
    cfg_word2 = 16'hFFFF;
    new_source_select = 3'h0;
    postscale_sel = 3'h1;
    src_case(3'h7, 2'h3, FH, 1, 2);
    src_case(3'h6, 2'h3, 0, 1, 1);
    src_case(3'h5, 2'h3, LH, 1, 1);
    src_case(3'h4, 2'h3, SH, 1, 1);
    src_case(3'h3, 2'h1, PH, 4, 1);
    src_case(3'h3, 2'h0, PH, 4, 1);
    src_case(3'h2, 2'h2, PH, 1, 1);
    src_case(3'h2, 2'h1, PH, 1, 1);
    src_case(3'h2, 2'h0, PH, 1, 1);
    src_case(3'h1, 2'h3, FH, 4, 1);
    src_case(3'h0, 2'h3, FH, 1, 1);
    boot(3'h0, 2'h1, 2'h3);
    chk("sw on", 2'h2, {switch_enable, failsafe_clock_monitor});
    req(3'h4, 3'h4, 1'b1);
    req(3'h6, 3'h4, 1'b1);
    req(3'h5, 3'h5, 1'b1);
    boot(3'h0, 2'h0, 2'h3);
    chk("mon on", 2'h3, {switch_enable, failsafe_clock_monitor});
    boot(3'h0, 2'h2, 2'h3);
    chk("sw off", 2'h0, {switch_enable, failsafe_clock_monitor});
    req(3'h4, 3'h0, 1'b0);
    @(posedge clk);
    cfg_word2 <= 16'h0000;
    repeat (20) @(posedge clk);
    #1;
    chk("held", 5'h03, {current_source_status, primary_mode_cfg});
    close_out;
  end
endmodule
`default_nettype wire
